/* File: rtl/dsp_access_cfg.svh */
// Purpose: constants for the indirect signal-processor parameter port
// Assumes: byte-wide port registers, 14-bit parameter words
// Notes: definitions only
`ifndef DSP_ACCESS_CFG_SVH
`define DSP_ACCESS_CFG_SVH

// Port register indices on the byte port
`define PORT_LOW 2'h0
`define PORT_HIGH 2'h1
`define PORT_FSEL 2'h2

// Function selector values
`define SEL_ADDR 8'h00
`define SEL_DATA 8'h01
`define SEL_CTRL 8'h02
`define SEL_RESET 8'h00

// Widths
`define ADDR_W 16
`define WORD_W 14
`define WORD_HI_W 6
`define PARAM_N 15

// Parameter addresses
`define PA_TX_LEVEL 16'h0002
`define PA_DTMF_HI 16'h0003
`define PA_TWIST 16'h0004
`define PA_USER_FREQ 16'h0005
`define PA_PROG_THR 16'h0006
`define PA_CENTRE_1 16'h0007
`define PA_CENTRE_2 16'h0008
`define PA_CENTRE_3 16'h0009
`define PA_CENTRE_4 16'h000A
`define PA_GEN_LEVEL 16'h000B
`define PA_SENS 16'h000E
`define PA_CARR_ON 16'h0024
`define PA_CARR_OFF 16'h0025
`define PA_ANS_ON 16'h0026
`define PA_ANS_OFF 16'h0027
`define PA_COEF_FIRST 16'h0010
`define PA_COEF_LAST 16'h0023

// Parameter reset values
`define RV_TX_LEVEL 14'h1000
`define RV_DTMF_HI 14'h1304
`define RV_TWIST 14'h0CCD
`define RV_USER_FREQ 14'h005B
`define RV_PROG_THR 14'h1000
`define RV_CENTRE_A 14'h137B
`define RV_CENTRE_B 14'h0218
`define RV_GEN_LEVEL 14'h0B50
`define RV_SENS 14'h1000
`define RV_CARR_ON 14'h0A3C
`define RV_CARR_OFF 14'h0CE4
`define RV_ANS_ON 14'h0043
`define RV_ANS_OFF 14'h0025

// Status view bits
`define ST_AVAIL 7
`define ST_TONE 6

// Detect configuration view bits
`define CF_SQUARE 7
`define CF_CASC_DIS 6
`define CF_EN_HI 4

// Tone control view fields
`define TC_DIGIT_HI 6
`define TC_DIGIT_LO 3
`define TC_TYPE_HI 2

// Reported tone type codes
`define TT_NONE 5'h00
`define TT_ANSWER 5'h01
`define TT_V23 5'h02
`define TT_USER_BASE 5'h04
`define TT_DTMF_BASE 5'h10

`endif

/* File: rtl/dsp_access_pkg.sv */
// Purpose: types for the indirect parameter port
// Assumes: nothing
// Notes: constants live in dsp_access_cfg.svh
package dsp_access_pkg;
  typedef enum logic [2:0]
  {
    SEQ_IDLE = 3'b001,
    SEQ_ADDR = 3'b010,
    SEQ_HIGH = 3'b100
  } seq_state_t;
endpackage

/* File: rtl/dsp_indirect_register_access.sv */
// Purpose: indirect byte port to the signal-processor parameter registers
// Assumes: port strobes, hook and mode levels come from logic on clk
// Notes: selector picks address, data or control views of two bytes;
//   selector values above 0x02 leave both ports inert, and a low data
//   byte with no address since reset is dropped
//
// Overview of operation
// R1: Parameter writes accepted only on-hook and in command mode.
// R2: Port carries a 16-bit address and a 14-bit data word.
// R3: Host supplies the address first, then the data word.
// R4: Selector 0x00: low port loads address [7:0], high loads [15:8].
// R5: Selector 0x01: ports supply data bytes for the last loaded address.
// R6: Data high byte gives upper six bits, low byte lower eight.
// R7: Read and write views differ for the same selector value.
// R8: Selector 0x02 low read: available, tone detected, reserved, tone type.
// R9: Selector 0x02 high write: squaring, cascade disable, reporting enables.
// R10: Selector 0x02 low write: DTMF digit [6:3], tone type [2:0].
// R11: Host writes only listed addresses with in-range values.
// R12: Address 0x0002 is transmit full-scale level, default 4096.
// R13: 0x0003 DTMF high-tone level 4868; 0x0004 twist ratio 3277.
// R14: Address 0x0005 is user tone frequency code, default 91.
// R15: Address 0x0006 is call-progress detect threshold, default 4096.
// R16: Addresses 0x0007 to 0x000A are detector centres, 4987/536 alternating.
// R17: Address 0x000B is generated tone amplitude, default 2896.
// R18: Address 0x000E is detector sensitivity, default 4096.
// R19: Carrier on level 0x0024 (2620), carrier off level 0x0025 (3300).
// R20: Answer on level 0x0026 (67), answer off level 0x0027 (37).
// R21: Filter coefficients at 0x0010 to 0x0023 use the same port.
// R22: Reported tone is the enabled detection of highest priority.
// R23: Low data byte write commits the assembled word, after high byte.
`timescale 1ns/1ps
`include "dsp_access_cfg.svh"
module dsp_indirect_register_access
  import dsp_access_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic port_wr,
  input wire logic port_rd,
  input wire logic [1:0] port_sel,
  input wire logic [7:0] port_wdata,
  output logic [7:0] port_rdata,
  input wire logic line_on_hook,
  input wire logic cmd_mode,
  input wire logic dsp_data_avail,
  input wire logic det_dtmf,
  input wire logic [3:0] det_dtmf_digit,
  input wire logic det_answer,
  input wire logic det_v23,
  input wire logic [3:0] det_user,
  output logic [7:0] func_select,
  output logic [`PARAM_N*`WORD_W-1:0] param_values,
  output logic coef_wr,
  output logic [15:0] coef_addr,
  output logic [13:0] coef_data,
  output logic squaring_en,
  output logic cascade_dis,
  output logic [4:0] report_en,
  output logic [3:0] dtmf_tx_digit,
  output logic [2:0] tone_type_select,
  output logic write_refused,
  output logic write_unmapped
);
  logic [7:0] sel_r;
  logic [15:0] addr_r;
  logic [5:0] word_hi_r;
  seq_state_t seq_r;
  seq_state_t seq_nxt;
  logic [7:0] rdata_r;
  logic [7:0] cfg_r;
  logic [6:0] tonec_r;
  logic coef_wr_r;
  logic [15:0] coef_addr_r;
  logic [13:0] coef_data_r;
  logic refused_r;
  logic unmapped_r;

  logic wr_low;
  logic wr_high;
  logic wr_fsel;
  logic mode_addr;
  logic mode_data;
  logic mode_ctrl;
  logic allowed;
  logic commit;
  logic [13:0] word;
  logic bank_hit;
  logic coef_hit;
  logic tone_found;
  logic [4:0] tone_code;
  logic [7:0] status_view;
  logic [7:0] rdata_nxt;
  logic addr_wr;
  logic data_wr;

  // Port index 3 is unused; a strobe there decodes to nothing
  always_comb
  begin
    wr_low = 1'b0;
    wr_high = 1'b0;
    wr_fsel = 1'b0;
    case (port_sel)
      `PORT_LOW:
        wr_low = port_wr;
      `PORT_HIGH:
        wr_high = port_wr;
      `PORT_FSEL:
        wr_fsel = port_wr;
      default:
        wr_fsel = 1'b0;
    endcase
  end

  // Selector values above 0x02 leave every view idle
  always_comb
  begin
    mode_addr = 1'b0;
    mode_data = 1'b0;
    mode_ctrl = 1'b0;
    case (sel_r)
      `SEL_ADDR:
        mode_addr = 1'b1;
      `SEL_DATA:
        mode_data = 1'b1;
      `SEL_CTRL:
        mode_ctrl = 1'b1;
      default:
        mode_ctrl = 1'b0;
    endcase
  end

  // Byte writes that carry address or data, not selector changes
  assign addr_wr = mode_addr && (wr_low || wr_high);
  assign data_wr = mode_data && (wr_low || wr_high);

  // Writes into parameter storage only while idle on the line
  assign allowed = line_on_hook && cmd_mode; // see R1

  // Word is six held high bits over the low byte being written
  assign word = {word_hi_r, port_wdata}; // see R6

  // Commit needs an address loaded first; data before address is dropped
  assign commit = wr_low && mode_data && allowed && (seq_r != SEQ_IDLE); // see R3, R23

  assign coef_hit = (addr_r >= `PA_COEF_FIRST) && (addr_r <= `PA_COEF_LAST); // see R21

  // Function selector, writable at any time
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sel_r <= `SEL_RESET;
    else if (wr_fsel)
      sel_r <= port_wdata;
  end

  // Address bytes in address mode
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      addr_r <= 16'h0000;
    else if (mode_addr && wr_low)
      addr_r[7:0] <= port_wdata; // see R2, R4
    else if (mode_addr && wr_high)
      addr_r[15:8] <= port_wdata; // see R4
  end

  // High data byte; only six bits carry weight
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      word_hi_r <= 6'h00;
    else if (addr_wr)
      word_hi_r <= 6'h00;
    else if (mode_data && wr_high && allowed)
      word_hi_r <= port_wdata[`WORD_HI_W-1:0]; // see R5, R6
  end

  // Write sequence: address, optional high byte, low byte commits
  always_comb
  begin
    seq_nxt = seq_r;
    case (seq_r)
      SEQ_IDLE:
      begin
        if (addr_wr)
          seq_nxt = SEQ_ADDR; // see R3
      end
      SEQ_ADDR:
      begin
        if (mode_data && wr_high && allowed)
          seq_nxt = SEQ_HIGH;
      end
      SEQ_HIGH:
      begin
        if (commit)
          seq_nxt = SEQ_ADDR;
        else if (addr_wr)
          seq_nxt = SEQ_ADDR;
      end
      default:
        seq_nxt = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      seq_r <= SEQ_IDLE;
    else
      seq_r <= seq_nxt;
  end

  param_bank u_bank
  (
    .clk(clk),
    .arst_n(arst_n),
    .wr(commit),
    .addr(addr_r),
    .data(word),
    .hit(bank_hit),
    .values(param_values)
  );

  // Coefficients live in the filter block; hand them over as a strobe
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      coef_wr_r <= 1'b0;
    else
      coef_wr_r <= commit && coef_hit; // see R21
  end

  // Address and word stay put after the strobe so the filter may take them late
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      coef_addr_r <= 16'h0000;
      coef_data_r <= 14'h0000;
    end
    else if (commit && coef_hit)
    begin
      coef_addr_r <= addr_r;
      coef_data_r <= word;
    end
  end

  // Data-mode byte while off-hook or online: pulse, nothing stored
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      refused_r <= 1'b0;
    else
      refused_r <= data_wr && !allowed; // see R1
  end

  // Unlisted targets are dropped rather than stored, see R11
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      unmapped_r <= 1'b0;
    else
      unmapped_r <= commit && !bank_hit && !coef_hit;
  end

  // Detector configuration view, write side of the high port
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cfg_r <= 8'h00;
    else if (mode_ctrl && wr_high)
      cfg_r <= port_wdata & 8'hDF; // see R9
  end

  // Tone transmit view, write side of the low port
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      tonec_r <= 7'h00;
    else if (mode_ctrl && wr_low)
      tonec_r <= port_wdata[6:0]; // see R10
  end

  tone_priority u_prio
  (
    .enable(cfg_r[`CF_EN_HI:0]),
    .det_dtmf(det_dtmf),
    .det_dtmf_digit(det_dtmf_digit),
    .det_answer(det_answer),
    .det_v23(det_v23),
    .det_user(det_user),
    .found(tone_found),
    .tone_type(tone_code)
  );

  // Reserved bit 5 reads as zero
  always_comb
  begin
    status_view = 8'h00;
    status_view[`ST_AVAIL] = dsp_data_avail; // see R8
    status_view[`ST_TONE] = tone_found; // see R22
    status_view[4:0] = tone_code;
  end

  // Read side: only the status view and the selector itself are readable
  always_comb
  begin
    rdata_nxt = 8'h00;
    case (port_sel)
      `PORT_LOW:
      begin
        if (mode_ctrl)
          rdata_nxt = status_view; // see R7, R8
      end
      `PORT_FSEL:
        rdata_nxt = sel_r;
      default:
        rdata_nxt = 8'h00;
    endcase
  end

  // Data holds between reads
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_r <= 8'h00;
    else if (port_rd)
      rdata_r <= rdata_nxt;
  end

  assign port_rdata = rdata_r;
  assign func_select = sel_r;
  assign coef_wr = coef_wr_r;
  assign coef_addr = coef_addr_r;
  assign coef_data = coef_data_r;
  assign squaring_en = cfg_r[`CF_SQUARE]; // see R9
  assign cascade_dis = cfg_r[`CF_CASC_DIS];
  assign report_en = cfg_r[`CF_EN_HI:0];
  assign dtmf_tx_digit = tonec_r[`TC_DIGIT_HI:`TC_DIGIT_LO]; // see R10
  assign tone_type_select = tonec_r[`TC_TYPE_HI:0];
  assign write_refused = refused_r;
  assign write_unmapped = unmapped_r;
endmodule

/* File: rtl/param_bank.sv */
// Purpose: storage for the fifteen 14-bit parameter registers
// Assumes: writes arrive already gated and assembled
// Notes: hit is combinational on the presented address
`timescale 1ns/1ps
`include "dsp_access_cfg.svh"
module param_bank
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wr,
  input wire logic [15:0] addr,
  input wire logic [13:0] data,
  output logic hit,
  output logic [`PARAM_N*`WORD_W-1:0] values
);
  localparam logic [15:0] MAP_ADDR [`PARAM_N] = '{
    `PA_TX_LEVEL, `PA_DTMF_HI, `PA_TWIST, `PA_USER_FREQ, `PA_PROG_THR,
    `PA_CENTRE_1, `PA_CENTRE_2, `PA_CENTRE_3, `PA_CENTRE_4, `PA_GEN_LEVEL,
    `PA_SENS, `PA_CARR_ON, `PA_CARR_OFF, `PA_ANS_ON, `PA_ANS_OFF};
  localparam logic [13:0] MAP_RST [`PARAM_N] = '{
    `RV_TX_LEVEL, `RV_DTMF_HI, `RV_TWIST, `RV_USER_FREQ, `RV_PROG_THR,
    `RV_CENTRE_A, `RV_CENTRE_B, `RV_CENTRE_A, `RV_CENTRE_B, `RV_GEN_LEVEL,
    `RV_SENS, `RV_CARR_ON, `RV_CARR_OFF, `RV_ANS_ON, `RV_ANS_OFF};

  logic [`PARAM_N-1:0] match;

  genvar i;
  generate
    for (i = 0; i < `PARAM_N; i++)
    begin : g_param
      logic [13:0] val_r;
      assign match[i] = (addr == MAP_ADDR[i]);
      // Levels, frequency and detector codes, see R12, R13, R14, R15, R16, R17, R18, R19, R20
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          val_r <= MAP_RST[i];
        else if (wr && match[i])
          val_r <= data;
      end
      assign values[i*`WORD_W +: `WORD_W] = val_r;
    end
  endgenerate

  assign hit = |match;
endmodule

/* File: rtl/tone_priority.sv */
// Purpose: picks the reported tone among enabled detections
// Assumes: detection inputs are levels on the same clock
// Notes: fixed order answer, V.23, DTMF, user 1 to 4
`timescale 1ns/1ps
`include "dsp_access_cfg.svh"
module tone_priority
(
  input wire logic [4:0] enable,
  input wire logic det_dtmf,
  input wire logic [3:0] det_dtmf_digit,
  input wire logic det_answer,
  input wire logic det_v23,
  input wire logic [3:0] det_user,
  output logic found,
  output logic [4:0] tone_type
);
  logic [3:0] user_ok;

  assign user_ok = det_user & {enable[4], enable[4], enable[3], enable[3]};

  // Highest enabled detection wins, see R22
  always_comb
  begin
    found = 1'b1;
    tone_type = `TT_NONE;
    if (det_answer && enable[1])
      tone_type = `TT_ANSWER;
    else if (det_v23 && enable[2])
      tone_type = `TT_V23;
    else if (det_dtmf && enable[0])
      tone_type = `TT_DTMF_BASE | {1'b0, det_dtmf_digit};
    else if (user_ok[0])
      tone_type = `TT_USER_BASE;
    else if (user_ok[1])
      tone_type = `TT_USER_BASE + 5'h01;
    else if (user_ok[2])
      tone_type = `TT_USER_BASE + 5'h02;
    else if (user_ok[3])
      tone_type = `TT_USER_BASE + 5'h03;
    else
      found = 1'b0;
  end
endmodule

/* File: verif/dsp_access_props.sv */
// Purpose: port-level checks of the indirect parameter port
// Assumes: one clock, async active-low reset
// Notes: bound to the top module at the foot of this file
`timescale 1ns/1ps
`include "dsp_access_cfg.svh"
module dsp_access_props
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic port_wr,
  input wire logic port_rd,
  input wire logic [1:0] port_sel,
  input wire logic [7:0] port_wdata,
  input wire logic [7:0] port_rdata,
  input wire logic line_on_hook,
  input wire logic cmd_mode,
  input wire logic dsp_data_avail,
  input wire logic [7:0] func_select,
  input wire logic [`PARAM_N*`WORD_W-1:0] param_values,
  input wire logic coef_wr,
  input wire logic [15:0] coef_addr,
  input wire logic squaring_en,
  input wire logic cascade_dis,
  input wire logic [4:0] report_en,
  input wire logic [3:0] dtmf_tx_digit,
  input wire logic [2:0] tone_type_select,
  input wire logic write_refused
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic wr_lo;
  logic wr_hi;
  logic gated;
  assign wr_lo = port_wr && port_sel == `PORT_LOW;
  assign wr_hi = port_wr && port_sel == `PORT_HIGH;
  assign gated = !(line_on_hook && cmd_mode);

  refused_pulse_a: assert property ((wr_lo || wr_hi) && func_select == `SEL_DATA && gated
    |=> write_refused) else $error("gated data write not flagged");
  refused_hold_a: assert property (wr_lo && func_select == `SEL_DATA && gated
    |=> $stable(param_values)) else $error("gated data write changed a parameter");
  select_track_a: assert property (port_wr && port_sel == `PORT_FSEL
    |=> func_select == $past(port_wdata)) else $error("selector not taken");
  config_view_a: assert property (wr_hi && func_select == `SEL_CTRL
    |=> {squaring_en, cascade_dis, report_en} == {$past(port_wdata[7:6]), $past(port_wdata[4:0])})
    else $error("detect config not taken");
  tone_ctrl_a: assert property (wr_lo && func_select == `SEL_CTRL
    |=> {dtmf_tx_digit, tone_type_select} == $past(port_wdata[6:0]))
    else $error("tone control not taken");
  status_read_a: assert property (port_rd && port_sel == `PORT_LOW && func_select == `SEL_CTRL
    |=> port_rdata[7] == $past(dsp_data_avail) && !port_rdata[5]) else $error("status view wrong");
  high_read_zero_a: assert property (port_rd && port_sel == `PORT_HIGH
    |=> port_rdata == 8'h00) else $error("high port read not zero");
  coef_range_a: assert property (coef_wr |-> coef_addr >= `PA_COEF_FIRST
    && coef_addr <= `PA_COEF_LAST) else $error("coefficient commit out of range");
  commit_cause_a: assert property (coef_wr |-> $past(wr_lo)
    && $past(func_select) == `SEL_DATA) else $error("commit without low data byte");

  cover property (write_refused);
  cover property (coef_wr);
  cover property (port_rd && func_select == `SEL_CTRL);
endmodule

bind dsp_indirect_register_access dsp_access_props props_i
(
  .clk(clk), .arst_n(arst_n), .port_wr(port_wr), .port_rd(port_rd), .port_sel(port_sel),
  .port_wdata(port_wdata), .port_rdata(port_rdata), .line_on_hook(line_on_hook),
  .cmd_mode(cmd_mode), .dsp_data_avail(dsp_data_avail), .func_select(func_select),
  .param_values(param_values), .coef_wr(coef_wr), .coef_addr(coef_addr),
  .squaring_en(squaring_en), .cascade_dis(cascade_dis), .report_en(report_en),
  .dtmf_tx_digit(dtmf_tx_digit), .tone_type_select(tone_type_select),
  .write_refused(write_refused)
);

/* File: verif/host_port.sv */
// Purpose: host side of the byte port
// Assumes: every task is entered right after a rising edge
// Notes: released data lines show the inverse of the last byte
`timescale 1ns/1ps
`include "dsp_access_cfg.svh"
module host_port
(
  input wire logic clk,
  input wire logic [7:0] port_rdata,
  output logic port_wr,
  output logic port_rd,
  output logic [1:0] port_sel,
  output logic [7:0] port_wdata
);
  initial
  begin
    port_wr = 1'b0;
    port_rd = 1'b0;
    port_sel = 2'h3;
    port_wdata = 8'h00;
  end
  task automatic put(input logic [1:0] sel, input logic [7:0] d);
    #1;
    port_wr = 1'b1;
    port_rd = 1'b0;
    port_sel = sel;
    port_wdata = d;
    @(posedge clk);
  endtask
  task automatic get(input logic [1:0] sel, output logic [7:0] d);
    #1;
    port_wr = 1'b0;
    port_rd = 1'b1;
    port_sel = sel;
    port_wdata = ~port_wdata;
    @(posedge clk);
    #1;
    port_rd = 1'b0;
    d = port_rdata;
    @(posedge clk);
  endtask
  task automatic idle();
    #1;
    port_wr = 1'b0;
    port_wdata = ~port_wdata;
    @(posedge clk);
  endtask
  // Callers keep to listed addresses unless probing a drop
  task automatic param_write(input logic [15:0] a, input logic [7:0] hi, input logic [7:0] lo);
    put(`PORT_FSEL, `SEL_ADDR);
    put(`PORT_HIGH, a[15:8]);
    put(`PORT_LOW, a[7:0]);
    put(`PORT_FSEL, `SEL_DATA);
    put(`PORT_HIGH, hi);
    put(`PORT_LOW, lo);
    idle();
  endtask
endmodule

/* File: verif/testbench.sv */
// Purpose: self-checking bench for the indirect parameter port
// Assumes: host_port drives the byte port, the bench drives line and detection levels
// Notes: random values come from a fixed seed
`timescale 1ns/1ps
`include "dsp_access_cfg.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module testbench
  import dsp_access_pkg::*;
;
  logic clk, arst_n, on_hook, cmd, avail, dtmf, ans, v23, coef_wr, sq, cd, refused, unmapped;
  logic [3:0] digit, user, tx_digit;
  logic [1:0] port_sel;
  logic port_wr, port_rd;
  logic [7:0] port_wdata, port_rdata, func_select, b, rd;
  logic [`PARAM_N*`WORD_W-1:0] param_values;
  logic [15:0] coef_addr, w;
  logic [13:0] coef_data, old;
  logic [4:0] report_en;
  logic [2:0] tone_sel;
  logic [11:0] r;
  logic [7:0] coef_cnt = 8'h00, unmapped_cnt = 8'h00, refused_cnt = 8'h00;
  integer seed, i, compares = 0, n_errors = 0;
  logic [13:0] dflt [15] = '{14'h1000, 14'h1304, 14'h0CCD, 14'h005B, 14'h1000, 14'h137B,
    14'h0218, 14'h137B, 14'h0218, 14'h0B50, 14'h1000, 14'h0A3C, 14'h0CE4, 14'h0043, 14'h0025};
  logic [7:0] pa [15] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A,
    8'h0B, 8'h0E, 8'h24, 8'h25, 8'h26, 8'h27};

  host_port host (.clk(clk), .port_rdata(port_rdata), .port_wr(port_wr), .port_rd(port_rd),
    .port_sel(port_sel), .port_wdata(port_wdata));
  dsp_indirect_register_access dut (.clk(clk), .arst_n(arst_n), .port_wr(port_wr),
    .port_rd(port_rd), .port_sel(port_sel), .port_wdata(port_wdata), .port_rdata(port_rdata),
    .line_on_hook(on_hook), .cmd_mode(cmd), .dsp_data_avail(avail), .det_dtmf(dtmf),
    .det_dtmf_digit(digit), .det_answer(ans), .det_v23(v23), .det_user(user),
    .func_select(func_select), .param_values(param_values), .coef_wr(coef_wr),
    .coef_addr(coef_addr), .coef_data(coef_data), .squaring_en(sq), .cascade_dis(cd),
    .report_en(report_en), .dtmf_tx_digit(tx_digit), .tone_type_select(tone_sel),
    .write_refused(refused), .write_unmapped(unmapped));

  // Detection word r is {avail, answer, v23, dtmf, digit, user}; later checks override earlier
  function automatic logic [7:0] status_of(input logic [4:0] en, input logic [11:0] r);
    logic [4:0] t;
    t = 5'h00;
    for (int u = 3; u >= 0; u--)
      if (en[3 + u / 2] && r[u]) t = 5'h04 + 5'(u);
    if (en[0] && r[8]) t = {1'b1, r[7:4]};
    if (en[2] && r[9]) t = 5'h02;
    if (en[1] && r[10]) t = 5'h01;
    return {r[11], t != 5'h00, 1'b0, t};
  endfunction

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Pulses last one cycle, so they are counted at the edge rather than polled
  always @(posedge clk)
  begin
    if (coef_wr === 1'b1) coef_cnt++;
    if (unmapped === 1'b1) unmapped_cnt++;
    if (refused === 1'b1) refused_cnt++;
  end
  initial
  begin
    #10000;
    n_errors++;
    conclude();
  end

  initial
  begin
    seed = 32'h3D55;
    {arst_n, on_hook, cmd, avail, ans, v23, dtmf, digit, user} = 15'h3000;
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    @(posedge clk);
    for (int k = 0; k < 15; k++)
      `CHK(param_values[k*14 +: 14], dflt[k])
    `CHK(func_select, 8'h00)
    $display("test reset done");
    for (int k = 0; k < 12; k++)
    begin
      i = $unsigned($random(seed)) % 15;
      w = 16'($random(seed));
      host.param_write({8'h00, pa[i]}, w[15:8], w[7:0]);
      `CHK(param_values[i*14 +: 14], w[13:0])
    end
    host.put(`PORT_HIGH, 8'hFF);
    host.put(`PORT_LOW, 8'h00);
    host.idle();
    `CHK(param_values[i*14 +: 14], 14'h3F00)
    $display("test param writes done");
    old = param_values[13:0];
    for (int g = 0; g < 3; g++)
    begin
      {on_hook, cmd} <= #1 2'(g);
      host.param_write(16'h0002, 8'h3F, 8'hFF);
      `CHK(param_values[13:0], old)
    end
    {on_hook, cmd} <= #1 2'b11;
    host.param_write(16'h0015, 8'h01, 8'h35);
    host.param_write(16'h0001, 8'h12, 8'h34);
    host.idle();
    `CHK({refused_cnt, coef_cnt, unmapped_cnt}, {8'h06, 8'h01, 8'h01})
    `CHK({coef_addr, coef_data}, {16'h0015, 14'h0135})
    $display("test gating and coefficients done");
    host.put(`PORT_FSEL, `SEL_CTRL);
    for (int t = 0; t < 8; t++)
    begin
      b = 8'($random(seed));
      host.put(`PORT_HIGH, b);
      host.put(`PORT_LOW, {b[7:3], 3'(t)});
      host.idle();
      `CHK({sq, cd, report_en}, {b[7:6], b[4:0]})
      `CHK({tx_digit, tone_sel}, {b[6:3], 3'(t)})
    end
    for (int k = 0; k < 16; k++)
    begin
      b = (k == 0) ? 8'h1F : 8'($random(seed));
      r = (k == 0) ? 12'hFFF : 12'($random(seed));
      host.put(`PORT_HIGH, b);
      {avail, ans, v23, dtmf, digit, user} <= #1 r;
      host.get(`PORT_LOW, rd);
      `CHK(rd, status_of(b[4:0], r))
    end
    host.get(`PORT_HIGH, rd);
    `CHK(rd, 8'h00)
    host.put(`PORT_FSEL, `SEL_DATA);
    host.get(`PORT_FSEL, rd);
    `CHK(rd, 8'h01)
    host.get(`PORT_LOW, rd);
    `CHK(rd, 8'h00)
    $display("test control and status done");
    conclude();
  end
endmodule
